// ### rtl/stc_defs.vh
// shared constants of the signalling table classifier
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define STC_CLK_HZ 10000000
`define STC_REFRESH_S 10
`define STC_NCR_PER_S 10
`define STC_TXOFF_S 1
`define STC_TMR_W 27

// ----------------------------------------
// table header layout, four bytes
// ----------------------------------------
`define STC_VER_MSB 5
`define STC_VER_LSB 1
`define STC_CNI_BIT 0

// ----------------------------------------
// table identifiers
// ----------------------------------------
`define STC_TID_NIT 8'h40
`define STC_TID_RMT 8'h41
`define STC_TID_TDT 8'h70
`define STC_TID_SCT 8'ha0
`define STC_TID_SPT 8'ha3
`define STC_TID_CMT 8'ha4
`define STC_TID_FCT2 8'hab
`define STC_TID_BCT 8'hac
`define STC_TID_TBTP2 8'had
`define STC_TID_TMST2 8'hae
`define STC_TID_FAT 8'haf
`define STC_TID_TIM 8'hb0
`define STC_TID_FECP 8'hb1
`define STC_TID_MMT2 8'hb2
`define STC_TID_USER_LO 8'hc0
`define STC_TID_SYNC 8'hff

// ----------------------------------------
// table class codes on tbl_class
// ----------------------------------------
`define STC_CLS_NIT 5'h00
`define STC_CLS_RMT 5'h01
`define STC_CLS_TDT 5'h02
`define STC_CLS_SCT 5'h03
`define STC_CLS_SPT 5'h04
`define STC_CLS_CMT 5'h05
`define STC_CLS_FCT2 5'h06
`define STC_CLS_BCT 5'h07
`define STC_CLS_TBTP2 5'h08
`define STC_CLS_TMST2 5'h09
`define STC_CLS_FAT 5'h0a
`define STC_CLS_TIM 5'h0b
`define STC_CLS_FECP 5'h0c
`define STC_CLS_MMT2 5'h0d
`define STC_CLS_RSVD 5'h0e
`define STC_CLS_USER 5'h0f
`define STC_CLS_SYNC 5'h10

// ----------------------------------------
// descriptor tags
// ----------------------------------------
`define STC_TAG_LINK 8'h4a
`define STC_TAG_NLI 8'ha0
`define STC_TAG_CORR 8'ha1
`define STC_TAG_CTRL 8'ha4
`define STC_TAG_FWD 8'ha8
`define STC_TAG_RET 8'ha9
`define STC_TAG_LOGON_RSP 8'hb9
`define STC_TAG_TXOFF 8'hbf
`define STC_TAG_RALC 8'hc0

// ----------------------------------------
// freshness tracker slots
// ----------------------------------------
`define STC_TRK_N 8
`define STC_TRK_SCT 0
`define STC_TRK_FCT2 1
`define STC_TRK_BCT 2
`define STC_TRK_SPT 3
`define STC_TRK_TMST2 4
`define STC_TRK_TIMB 5
`define STC_TRK_NCR 6
`define STC_TRK_TXOFF 7

`endif

// ### rtl/stc_fifo.v
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module stc_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire sys_rst,
	input wire wr_valid,
	output wire wr_ready,
	input wire [WIDTH-1:0] wr_data,
	output wire rd_valid,
	input wire rd_ready,
	output wire [WIDTH-1:0] rd_data
);

	// ----------------------------------------
	// storage and pointers
	// ----------------------------------------
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // word store
	reg [AW-1:0] wr_ptr; // next slot to fill
	reg [AW-1:0] rd_ptr; // next slot to drain
	reg [AW:0] count; // words held
	wire do_wr;
	wire do_rd;

	assign wr_ready = (count != DEPTH[AW:0]);
	assign rd_valid = (count != {(AW+1){1'b0}});
	assign rd_data = mem[rd_ptr];
	assign do_wr = wr_valid && wr_ready;
	assign do_rd = rd_valid && rd_ready;

	// write side of the store, no reset needed for data
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr_data;
		end
	end

	// pointer and fill count upkeep
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			// simultaneous push and pop keeps the count
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

// ### rtl/stc_classifier.v
// forward-link signalling table classifier and descriptor filter
// Contract
// - ids 0x40, 0x41, 0x70 classified
// - ids 0xa0, 0xa3, 0xa4 classified; 0xa1-0xa2 reserved
// - ids 0xab, 0xac, 0xad classified
// - ids 0xae to 0xb2 classified
// - 0xff sync, 0xc0-0xfe user, rest reserved
// - descriptors parsed as tag, length, value
// - unsupported descriptors dropped silently
// - unicast message tags a0, a1, a4, b9 decoded
// - tags bf and c0 only in access table
// - tag 4a in nit/rmt; a8/a9 rmt/unicast
// - tags c6 to fe discarded
// - table bytes taken from generic stream
// - configuration applied only after whole message
// - four-byte header: id, network, version, indicator
`timescale 1ns/100ps
`include "stc_defs.vh"
module stc_classifier #(
	parameter FIFO_DEPTH = 8,
	parameter REFRESH_CYCLES = `STC_REFRESH_S * `STC_CLK_HZ,
	parameter NCR_CYCLES = `STC_CLK_HZ / `STC_NCR_PER_S,
	parameter TXOFF_CYCLES = `STC_TXOFF_S * `STC_CLK_HZ
) (
	input wire clk,
	input wire sys_rst,
	input wire in_valid,
	output wire in_ready,
	input wire [7:0] in_data,
	input wire in_sot,
	input wire in_eot,
	input wire in_unicast,
	output reg tbl_valid,
	output reg [7:0] tbl_id,
	output reg [4:0] tbl_class,
	output reg [15:0] tbl_net_id,
	output reg [4:0] tbl_version,
	output reg tbl_current,
	output reg tbl_unicast,
	output reg tbl_end,
	output reg tbl_commit,
	output reg tbl_abort,
	output reg out_valid,
	input wire out_ready,
	output reg [7:0] out_tag,
	output reg [7:0] out_data,
	output reg out_first,
	output reg out_last,
	output reg out_raw,
	input wire ncr_update,
	input wire superframe_tick,
	output reg [`STC_TRK_N-1:0] table_fresh,
	output reg tbtp_fresh,
	output reg stale_alarm
);

	// ----------------------------------------
	// parser states, one-hot
	// ----------------------------------------
	localparam S_ID = 9'h001;
	localparam S_NET0 = 9'h002;
	localparam S_NET1 = 9'h004;
	localparam S_VER = 9'h008;
	localparam S_BODY = 9'h010;
	localparam S_TAG = 9'h020;
	localparam S_LEN = 9'h040;
	localparam S_VAL = 9'h080;
	localparam S_DROP = 9'h100;

	// ----------------------------------------
	// decoding functions
	// ----------------------------------------
	// map a table identifier to its class code
	function [4:0] classify;
		input [7:0] id;
		begin
			case (id)
				`STC_TID_NIT: classify = `STC_CLS_NIT;
				`STC_TID_RMT: classify = `STC_CLS_RMT;
				`STC_TID_TDT: classify = `STC_CLS_TDT;
				`STC_TID_SCT: classify = `STC_CLS_SCT;
				`STC_TID_SPT: classify = `STC_CLS_SPT;
				`STC_TID_CMT: classify = `STC_CLS_CMT;
				`STC_TID_FCT2: classify = `STC_CLS_FCT2;
				`STC_TID_BCT: classify = `STC_CLS_BCT;
				`STC_TID_TBTP2: classify = `STC_CLS_TBTP2;
				`STC_TID_TMST2: classify = `STC_CLS_TMST2;
				`STC_TID_FAT: classify = `STC_CLS_FAT;
				`STC_TID_TIM: classify = `STC_CLS_TIM;
				`STC_TID_FECP: classify = `STC_CLS_FECP;
				`STC_TID_MMT2: classify = `STC_CLS_MMT2;
				`STC_TID_SYNC: classify = `STC_CLS_SYNC;
				default: begin
					// user range, else reserved (0xa1, 0xa2, 0xb3-0xbf and the rest)
					classify = (id >= `STC_TID_USER_LO) ? `STC_CLS_USER : `STC_CLS_RSVD;
				end
			endcase
		end
	endfunction

	// tables whose content is a descriptor loop
	function has_desc;
		input [4:0] cls;
		begin
			has_desc = (cls == `STC_CLS_NIT) || (cls == `STC_CLS_RMT) ||
				(cls == `STC_CLS_TIM) || (cls == `STC_CLS_FAT);
		end
	endfunction

	// descriptor tags this terminal acts on, by table and addressing
	function desc_ok;
		input [4:0] cls;
		input uni;
		input [7:0] tag;
		begin
			case (cls)
				`STC_CLS_NIT: desc_ok = (tag == `STC_TAG_LINK);
				`STC_CLS_RMT: begin
					desc_ok = (tag == `STC_TAG_LINK) || (tag == `STC_TAG_FWD) ||
						(tag == `STC_TAG_RET);
				end
				`STC_CLS_FAT: begin
					desc_ok = (tag == `STC_TAG_TXOFF) || (tag == `STC_TAG_RALC);
				end
				`STC_CLS_TIM: begin
					if (uni) begin
						// unicast column
						case (tag)
							`STC_TAG_NLI, `STC_TAG_CORR, `STC_TAG_CTRL: desc_ok = 1'b1;
							`STC_TAG_LOGON_RSP: desc_ok = 1'b1;
							`STC_TAG_FWD, `STC_TAG_RET: desc_ok = 1'b1;
							8'ha6, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb6: desc_ok = 1'b1;
							8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hc1, 8'hc4: desc_ok = 1'b1;
							default: desc_ok = 1'b0;
						endcase
					end else begin
						// broadcast column
						case (tag)
							8'ha6, 8'hab, 8'hac, 8'hb2, 8'hb5, 8'hb6, 8'hb7: desc_ok = 1'b1;
							8'hb8, 8'hba, 8'hbc, 8'hbd, 8'hbe: desc_ok = 1'b1;
							8'hc1, 8'hc2, 8'hc5: desc_ok = 1'b1;
							default: desc_ok = 1'b0;
						endcase
					end
				end
				default: desc_ok = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// input buffer
	// ----------------------------------------
	wire f_valid; // buffered byte present
	wire f_pop; // parser takes the byte
	wire [10:0] f_word; // {sot, eot, unicast, byte}
	wire b_sot;
	wire b_eot;
	wire b_uni;
	wire [7:0] b_data;

	// whole tables arrive as one byte stream, no transport packets
	stc_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.wr_data({in_sot, in_eot, in_unicast, in_data}),
		.rd_valid(f_valid),
		.rd_ready(f_pop),
		.rd_data(f_word)
	);

	assign b_sot = f_word[10];
	assign b_eot = f_word[9];
	assign b_uni = f_word[8];
	assign b_data = f_word[7:0];
	// a held output byte stalls the parser and so fills the buffer
	assign f_pop = f_valid && (!out_valid || out_ready);

	// ----------------------------------------
	// header and descriptor parser
	// ----------------------------------------
	reg [8:0] state; // parser state
	reg [8:0] next_state;
	reg [7:0] rem; // value bytes left in descriptor
	reg [7:0] cur_tag; // tag of descriptor in flight
	reg keep; // descriptor in flight is supported
	reg first_pend; // next emitted value byte is first
	reg txoff_seen; // offset descriptor accepted this table
	wire [8:0] eff_state; // start of table forces the id state
	wire [4:0] cls_now; // class of the byte when it is an id

	assign eff_state = b_sot ? S_ID : state;
	assign cls_now = classify(b_data);

	// next state on each popped byte
	always @* begin
		next_state = eff_state;
		case (eff_state)
			S_ID: next_state = S_NET0;
			S_NET0: next_state = S_NET1;
			S_NET1: next_state = S_VER;
			S_VER: begin
				next_state = has_desc(tbl_class) ? S_TAG : S_BODY;
				if (tbl_class == `STC_CLS_SYNC) begin
					next_state = S_DROP;
				end
			end
			S_BODY: next_state = S_BODY;
			S_TAG: next_state = S_LEN;
			S_LEN: next_state = (b_data == 8'h00) ? S_TAG : S_VAL;
			S_VAL: next_state = (rem == 8'h01) ? S_TAG : S_VAL;
			S_DROP: next_state = S_DROP;
			default: next_state = S_ID;
		endcase
		if (b_eot) begin
			next_state = S_ID;
		end
	end

	// parser registers and table level outputs
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_ID;
			rem <= 8'h00;
			cur_tag <= 8'h00;
			keep <= 1'b0;
			first_pend <= 1'b0;
			txoff_seen <= 1'b0;
			tbl_valid <= 1'b0;
			tbl_id <= 8'h00;
			tbl_class <= `STC_CLS_RSVD;
			tbl_net_id <= 16'h0000;
			tbl_version <= 5'h00;
			tbl_current <= 1'b0;
			tbl_unicast <= 1'b0;
			tbl_end <= 1'b0;
			tbl_commit <= 1'b0;
			tbl_abort <= 1'b0;
		end else begin
			tbl_valid <= 1'b0;
			tbl_end <= 1'b0;
			tbl_commit <= 1'b0;
			tbl_abort <= 1'b0;
			if (f_pop) begin
				state <= next_state;
				case (eff_state)
					S_ID: begin
						tbl_id <= b_data;
						tbl_class <= cls_now;
						tbl_unicast <= b_uni;
						txoff_seen <= 1'b0;
					end
					S_NET0: tbl_net_id[15:8] <= b_data;
					S_NET1: tbl_net_id[7:0] <= b_data;
					S_VER: begin
						tbl_version <= b_data[`STC_VER_MSB:`STC_VER_LSB];
						tbl_current <= b_data[`STC_CNI_BIT];
						tbl_valid <= 1'b1;
					end
					S_TAG: begin
						cur_tag <= b_data;
						keep <= desc_ok(tbl_class, tbl_unicast, b_data);
					end
					S_LEN: begin
						rem <= b_data;
						first_pend <= 1'b1;
						if (keep && (cur_tag == `STC_TAG_TXOFF)) begin
							txoff_seen <= 1'b1;
						end
					end
					S_VAL: begin
						rem <= rem - 8'h01;
						first_pend <= 1'b0;
					end
					default: begin
						// body and drop states need no bookkeeping
					end
				endcase
				if (b_eot) begin
					tbl_end <= 1'b1;
					// changes apply only once every descriptor is through
					if (has_desc(tbl_class) && (next_state_clean(eff_state, rem, b_data))) begin
						tbl_commit <= 1'b1;
					end else if (has_desc(tbl_class) || (eff_state != S_BODY && eff_state != S_DROP)) begin
						tbl_abort <= 1'b1;
					end
				end
			end
		end
	end

	// table ended on a descriptor boundary
	function next_state_clean;
		input [8:0] st;
		input [7:0] r;
		input [7:0] d;
		begin
			next_state_clean = (st == S_TAG) ? 1'b0 :
				(st == S_LEN) ? (d == 8'h00) :
				(st == S_VAL) ? (r == 8'h01) : 1'b0;
		end
	endfunction

	// ----------------------------------------
	// output byte stream
	// ----------------------------------------
	wire emit_val; // supported value byte
	wire emit_raw; // content byte of a table without descriptors

	assign emit_val = (eff_state == S_VAL) && keep;
	assign emit_raw = (eff_state == S_BODY);

	// output register, holds until taken
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_tag <= 8'h00;
			out_data <= 8'h00;
			out_first <= 1'b0;
			out_last <= 1'b0;
			out_raw <= 1'b0;
		end else begin
			if (out_valid && out_ready) begin
				out_valid <= 1'b0;
			end
			if (f_pop && (emit_val || emit_raw)) begin
				out_valid <= 1'b1;
				out_data <= b_data;
				out_raw <= emit_raw;
				out_tag <= emit_raw ? tbl_id : cur_tag;
				out_first <= emit_raw ? 1'b0 : first_pend;
				out_last <= emit_raw ? b_eot : (rem == 8'h01);
			end
		end
	end

	// ----------------------------------------
	// freshness trackers
	// ----------------------------------------
	// window length for each tracker slot
	function [`STC_TMR_W-1:0] trk_limit;
		input integer idx;
		begin
			if (idx == `STC_TRK_NCR) begin
				trk_limit = NCR_CYCLES[`STC_TMR_W-1:0];
			end else if (idx == `STC_TRK_TXOFF) begin
				trk_limit = TXOFF_CYCLES[`STC_TMR_W-1:0];
			end else begin
				trk_limit = REFRESH_CYCLES[`STC_TMR_W-1:0];
			end
		end
	endfunction

	reg [`STC_TRK_N-1:0] arrive; // copy seen this cycle per slot
	wire [`STC_TRK_N-1:0] expire; // window ran out per slot

	// table arrivals count when a table completes, the ncr slot on ncr_update
	always @* begin
		arrive = {`STC_TRK_N{1'b0}};
		if (tbl_end) begin
			arrive[`STC_TRK_SCT] = (tbl_class == `STC_CLS_SCT);
			arrive[`STC_TRK_FCT2] = (tbl_class == `STC_CLS_FCT2);
			arrive[`STC_TRK_BCT] = (tbl_class == `STC_CLS_BCT);
			arrive[`STC_TRK_SPT] = (tbl_class == `STC_CLS_SPT);
			arrive[`STC_TRK_TMST2] = (tbl_class == `STC_CLS_TMST2);
			arrive[`STC_TRK_TIMB] = (tbl_class == `STC_CLS_TIM) && !tbl_unicast;
			arrive[`STC_TRK_TXOFF] = (tbl_class == `STC_CLS_FAT) && txoff_seen;
		end
		arrive[`STC_TRK_NCR] = ncr_update;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `STC_TRK_N; gi = gi + 1) begin : g_trk
			reg [`STC_TMR_W-1:0] age; // cycles since last copy
			assign expire[gi] = table_fresh[gi] && !arrive[gi] && (age >= trk_limit(gi));
			// age counter and fresh flag, arrival beats expiry
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					age <= {`STC_TMR_W{1'b0}};
					table_fresh[gi] <= 1'b0;
				end else if (arrive[gi]) begin
					age <= {{(`STC_TMR_W-1){1'b0}}, 1'b1};
					table_fresh[gi] <= 1'b1;
				end else if (expire[gi]) begin
					table_fresh[gi] <= 1'b0;
				end else if (table_fresh[gi]) begin
					age <= age + 1'b1;
				end
			end
		end
	endgenerate

	// burst plan must land between superframe ticks
	reg tbtp_seen; // plan arrived since last tick
	wire tbtp_arr;

	assign tbtp_arr = tbl_end && (tbl_class == `STC_CLS_TBTP2);

	// per-superframe plan watch and alarm pulse
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tbtp_seen <= 1'b0;
			tbtp_fresh <= 1'b0;
			stale_alarm <= 1'b0;
		end else begin
			if (superframe_tick) begin
				tbtp_fresh <= tbtp_seen || tbtp_arr;
				tbtp_seen <= tbtp_arr;
			end else if (tbtp_arr) begin
				tbtp_seen <= 1'b1;
			end
			stale_alarm <= (|expire) || (superframe_tick && tbtp_fresh && !tbtp_seen && !tbtp_arr);
		end
	end

endmodule

// ### verif/stc_ncc_model.sv
// control-centre signalling source model feeding table bytes
`timescale 1ns/100ps
module stc_ncc_model (
	input wire clk,
	input wire in_ready,
	output reg in_valid,
	output reg [7:0] in_data,
	output reg in_sot,
	output reg in_eot,
	output reg in_unicast
);
	// ----
	// byte driver
	// ----
	initial begin
		{in_valid, in_sot, in_eot, in_unicast, in_data} = 12'h000;
	end
	// offers one byte at a falling edge and holds it until ready is seen high
	task send(input [7:0] b, input bit s, input bit e, input bit u, output bit ok);
		integer n;
		@(negedge clk);
		{in_valid, in_sot, in_eot, in_unicast, in_data} = {1'b1, s, e, u, b};
		n = 0;
		@(posedge clk);
		while (in_ready !== 1'b1 && n < 200) begin
			n = n + 1;
			@(posedge clk);
		end
		ok = (n < 200);
	endtask
	// released stream shows the inverse of the last byte, never a stale copy
	task idle;
		@(negedge clk);
		{in_valid, in_sot, in_eot, in_data} = {3'b000, ~in_data};
	endtask
endmodule

// ### verif/stc_classifier_checker.sv
// port assertions of the table classifier
`timescale 1ns/100ps
`include "stc_defs.vh"
module stc_classifier_checker (
	input wire clk,
	input wire sys_rst,
	input wire out_valid,
	input wire out_ready,
	input wire [7:0] out_tag,
	input wire [7:0] out_data,
	input wire out_raw,
	input wire tbl_valid,
	input wire [7:0] tbl_id,
	input wire [4:0] tbl_class,
	input wire tbl_end,
	input wire tbl_commit,
	input wire tbl_abort,
	input wire [7:0] table_fresh,
	input wire stale_alarm
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire dsc = out_valid && !out_raw; // descriptor byte on offer
	chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable({out_tag, out_data})) else $error("output moved while stalled");
	chk_ids_base: assert property (tbl_valid |-> ((tbl_id == `STC_TID_NIT) == (tbl_class == `STC_CLS_NIT)) && ((tbl_id == `STC_TID_RMT) == (tbl_class == `STC_CLS_RMT)) && ((tbl_id == `STC_TID_TDT) == (tbl_class == `STC_CLS_TDT))) else $error("base id class wrong");
	chk_ids_frame: assert property (tbl_valid |-> ((tbl_id == `STC_TID_SCT) == (tbl_class == `STC_CLS_SCT)) && ((tbl_id == `STC_TID_SPT) == (tbl_class == `STC_CLS_SPT)) && ((tbl_id == `STC_TID_CMT) == (tbl_class == `STC_CLS_CMT))) else $error("frame id class wrong");
	chk_ids_plan: assert property (tbl_valid |-> ((tbl_id == `STC_TID_FCT2) == (tbl_class == `STC_CLS_FCT2)) && ((tbl_id == `STC_TID_BCT) == (tbl_class == `STC_CLS_BCT)) && ((tbl_id == `STC_TID_TBTP2) == (tbl_class == `STC_CLS_TBTP2))) else $error("plan id class wrong");
	chk_ids_msg: assert property (tbl_valid && tbl_id >= 8'hae && tbl_id <= 8'hb2 |-> tbl_class == tbl_id[4:0] - 5'h0e + `STC_CLS_TMST2) else $error("message id class wrong");
	chk_ids_rest: assert property (tbl_valid |-> ((tbl_id == `STC_TID_SYNC) == (tbl_class == `STC_CLS_SYNC)) && ((tbl_id >= 8'hc0 && tbl_id < 8'hff) == (tbl_class == `STC_CLS_USER))) else $error("spare id class wrong");
	chk_tag_drop: assert property (dsc |-> !(out_tag >= 8'hc6 && out_tag <= 8'hfe)) else $error("reserved tag passed");
	chk_fat_only: assert property (dsc && (out_tag == `STC_TAG_TXOFF || out_tag == `STC_TAG_RALC) |-> tbl_class == `STC_CLS_FAT) else $error("access tag outside fat");
	chk_link_place: assert property (dsc && out_tag == `STC_TAG_LINK |-> tbl_class == `STC_CLS_NIT || tbl_class == `STC_CLS_RMT) else $error("linkage misplaced");
	chk_commit_end: assert property (tbl_commit |-> tbl_end && !tbl_abort) else $error("commit without clean end");
	chk_stale_alarm: assert property (|($past(table_fresh) & ~table_fresh) |-> ##[0:1] stale_alarm) else $error("flag fell silently");
	// ----
	// coverage
	// ----
	cov_commit: cover property (tbl_commit);
	cov_abort: cover property (tbl_abort);
	cov_stall: cover property (out_valid && !out_ready);
	cov_alarm: cover property (stale_alarm);
endmodule
bind stc_classifier stc_classifier_checker chk_u (.clk, .sys_rst, .out_valid, .out_ready,
	.out_tag, .out_data, .out_raw, .tbl_valid, .tbl_id, .tbl_class, .tbl_end, .tbl_commit,
	.tbl_abort, .table_fresh, .stale_alarm);

// ### verif/tb_signalling_table_classifier.sv
// self-checking bench of the signalling table classifier
`timescale 1ns/100ps
`include "stc_defs.vh"
`define STC_CHK(nm, ex, gt) check_val(nm, ((ex) === (gt)), 32'(ex), 32'(gt))
module tb_signalling_table_classifier;
	localparam int REF_N = 2000; // shortened refresh limit
	localparam int NCR_N = 20;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg out_ready = 1'b0;
	reg ncr_update = 1'b0;
	reg superframe_tick = 1'b0;
	reg hold = 1'b0; // stalls the sink
	reg ncr_on = 1'b0;
	wire in_valid, in_ready, in_sot, in_eot, in_unicast, tbl_valid, tbl_current, tbl_unicast;
	wire tbl_end, tbl_commit, tbl_abort, out_valid, out_first, out_last, out_raw;
	wire tbtp_fresh, stale_alarm;
	wire [7:0] in_data, tbl_id, out_tag, out_data, table_fresh;
	wire [4:0] tbl_class, tbl_version;
	wire [15:0] tbl_net_id;
	integer mismatches = 0, check_count = 0, alarms = 0, full_cnt = 0, ends = 0, hdrs = 0;
	logic [1:0] e_ca; // commit and abort seen at table end
	logic [18:0] got_q[$], exp_q[$];
	logic [7:0] body_q[$];
	stc_classifier #(.REFRESH_CYCLES(REF_N), .NCR_CYCLES(NCR_N), .TXOFF_CYCLES(50)) dut_u (
		.clk, .sys_rst, .in_valid, .in_ready, .in_data, .in_sot, .in_eot, .in_unicast,
		.tbl_valid, .tbl_id, .tbl_class, .tbl_net_id, .tbl_version, .tbl_current,
		.tbl_unicast, .tbl_end, .tbl_commit, .tbl_abort, .out_valid, .out_ready, .out_tag,
		.out_data, .out_first, .out_last, .out_raw, .ncr_update, .superframe_tick,
		.table_fresh, .tbtp_fresh, .stale_alarm);
	stc_ncc_model pt_u (.clk, .in_ready, .in_valid, .in_data, .in_sot, .in_eot, .in_unicast);
	initial forever #50 clk = ~clk;
	// ----
	// monitors and background drivers
	// ----
	always @(posedge clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back({out_tag, out_data, out_first, out_last, out_raw});
		if (tbl_end === 1'b1) begin
			ends <= ends + 1;
			e_ca <= {tbl_commit, tbl_abort};
		end
		alarms <= alarms + (stale_alarm === 1'b1);
		hdrs <= hdrs + (tbl_valid === 1'b1);
		full_cnt <= full_cnt + (in_ready === 1'b0);
	end
	// random sink readiness; clock reference well inside its limit
	always @(negedge clk) begin
		out_ready <= !hold && ($urandom % 4 != 0);
		ncr_update <= ncr_on && (($time / 100) % 10 == 0);
	end
	// ----
	// tasks
	// ----
	task check_val(input string nm, input bit ok, input logic [31:0] ex, input logic [31:0] gt);
		check_count++;
		if (!ok) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, ex, gt);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task timeout;
		mismatches++;
		$display("mismatch wait expected done seen timeout");
		wrap_up();
	endtask
	task put(input [7:0] b, input bit s, input bit e, input bit u);
		bit ok;
		pt_u.send(b, s, e, u, ok);
		if (!ok) timeout();
	endtask
	// queues one descriptor; kept ones add their value bytes to the model
	task add_desc(input [7:0] tag, input integer len, input bit keep);
		logic [7:0] v;
		body_q.push_back(tag);
		body_q.push_back(len[7:0]);
		for (int i = 0; i < len; i++) begin
			v = $urandom;
			body_q.push_back(v);
			if (keep) exp_q.push_back({tag, v, i == 0, i == len - 1, 1'b0});
		end
	endtask
	// sends header and body, waits for the end and a drained output
	task send_tbl(input [7:0] id, input bit uni, input bit cmp, input [1:0] ca);
		logic [15:0] net;
		logic [7:0] vb;
		integer n, n0, h0;
		net = $urandom;
		vb = $urandom;
		n0 = ends;
		h0 = hdrs;
		got_q.delete();
		fork
			begin
				put(id, 1, 0, uni);
				put(net[15:8], 0, 0, uni);
				put(net[7:0], 0, 0, uni);
				put(vb, 0, 0, uni);
				foreach (body_q[i]) put(body_q[i], 0, i == body_q.size() - 1, uni);
				pt_u.idle();
			end
			if (hold) begin
				repeat (60) @(negedge clk);
				hold = 1'b0;
			end
		join
		for (n = 0; n < 400 && ((ends == n0 && id != 8'hff) || out_valid !== 1'b0); n++)
			@(negedge clk);
		if (n == 400) timeout();
		repeat (2) @(negedge clk);
		`STC_CHK("net label", net, tbl_net_id);
		`STC_CHK("table id", id, tbl_id);
		`STC_CHK("header pulse", h0 + 1, hdrs);
		`STC_CHK("version", vb[5:1], tbl_version);
		`STC_CHK("current", vb[0], tbl_current);
		`STC_CHK("unicast", uni, tbl_unicast);
		if (cmp) begin
			`STC_CHK("end flags", ca, e_ca);
			`STC_CHK("byte count", exp_q.size(), got_q.size());
			foreach (exp_q[i]) if (i < got_q.size()) `STC_CHK("out byte", exp_q[i], got_q[i]);
		end
		body_q.delete();
		exp_q.delete();
	endtask
	task tick;
		@(negedge clk) superframe_tick = 1'b1;
		@(negedge clk) superframe_tick = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// class expected for each table identifier
	function automatic logic [4:0] exp_cls(input [7:0] id);
		case (id)
			8'h40: return `STC_CLS_NIT;
			8'h41: return `STC_CLS_RMT;
			8'h70: return `STC_CLS_TDT;
			8'ha0: return `STC_CLS_SCT;
			8'ha3: return `STC_CLS_SPT;
			8'ha4: return `STC_CLS_CMT;
			8'hab: return `STC_CLS_FCT2;
			8'hac: return `STC_CLS_BCT;
			8'had: return `STC_CLS_TBTP2;
			8'hae: return `STC_CLS_TMST2;
			8'haf: return `STC_CLS_FAT;
			8'hb0: return `STC_CLS_TIM;
			8'hb1: return `STC_CLS_FECP;
			8'hb2: return `STC_CLS_MMT2;
			8'hff: return `STC_CLS_SYNC;
			default: return (id >= 8'hc0) ? `STC_CLS_USER : `STC_CLS_RSVD;
		endcase
	endfunction
	// ----
	// main sequence
	// ----
	initial begin
		static logic [7:0] ids[24] = '{8'h40, 8'h41, 8'h70, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hab,
			8'hac, 8'had, 8'hae, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hbf, 8'hc0, 8'hfe, 8'hff,
			8'h00, 8'h69, 8'h9f};
		integer f0, a0;
		void'($urandom(32'hefc0));
		repeat (4) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		`STC_CHK("fresh at reset", 8'h00, table_fresh);
		`STC_CHK("ready at reset", 1'b1, in_ready);
		foreach (ids[i]) begin
			body_q.push_back(8'h00);
			send_tbl(ids[i], 1'b0, 1'b0, 2'b00);
			`STC_CHK("class", exp_cls(ids[i]), tbl_class);
		end
		`STC_CHK("tables fresh", 5'h1f, table_fresh[4:0]);
		add_desc(8'ha0, 2, 1);
		add_desc(8'hc6, 1, 0);
		add_desc(8'ha4, 0, 1);
		add_desc(8'he0, 3, 0);
		add_desc(8'h00, 2, 0);
		add_desc(8'ha1, 1, 1);
		add_desc(8'ha8, 1, 1);
		add_desc(8'hb9, 1, 1);
		send_tbl(`STC_TID_TIM, 1'b1, 1'b1, 2'b10);
		add_desc(8'hbf, 2, 1);
		add_desc(8'ha0, 1, 0);
		add_desc(8'hc0, 1, 1);
		send_tbl(`STC_TID_FAT, 1'b0, 1'b1, 2'b10);
		`STC_CHK("offset fresh", 1'b1, table_fresh[7]);
		add_desc(8'h4a, 1, 1);
		add_desc(8'ha8, 1, 0);
		send_tbl(`STC_TID_NIT, 1'b0, 1'b1, 2'b10);
		add_desc(8'ha9, 2, 1);
		add_desc(8'h4a, 1, 1);
		send_tbl(`STC_TID_RMT, 1'b0, 1'b1, 2'b10);
		// revised broadcast message: broadcast column kept, unicast-only tag dropped
		add_desc(8'hab, 1, 1);
		add_desc(8'ha0, 1, 0);
		send_tbl(`STC_TID_TIM, 1'b0, 1'b1, 2'b10);
		// correction table has no descriptor loop, its bytes pass as raw content
		body_q = '{8'h5a, 8'h3c};
		exp_q = '{{8'ha4, 8'h5a, 3'b001}, {8'ha4, 8'h3c, 3'b011}};
		send_tbl(`STC_TID_CMT, 1'b0, 1'b1, 2'b00);
		add_desc(8'h4a, 3, 1);
		void'(body_q.pop_back());
		void'(body_q.pop_back());
		void'(exp_q.pop_back());
		void'(exp_q.pop_back());
		send_tbl(`STC_TID_NIT, 1'b0, 1'b1, 2'b01);
		f0 = full_cnt;
		hold = 1'b1;
		add_desc(8'ha0, 20, 1);
		add_desc(8'hb9, 2, 1);
		send_tbl(`STC_TID_TIM, 1'b1, 1'b1, 2'b10);
		`STC_CHK("buffer refused", 1'b1, full_cnt > f0);
		a0 = alarms;
		ncr_on = 1'b1;
		repeat (REF_N + 100) @(negedge clk);
		`STC_CHK("tables expired", 5'h00, table_fresh[4:0]);
		`STC_CHK("ncr kept fresh", 1'b1, table_fresh[6]);
		`STC_CHK("offset expired", 1'b0, table_fresh[7]);
		`STC_CHK("alarm raised", 1'b1, alarms > a0);
		ncr_on = 1'b0;
		repeat (NCR_N + 10) @(negedge clk);
		`STC_CHK("ncr stale", 1'b0, table_fresh[6]);
		body_q.push_back(8'h00);
		send_tbl(`STC_TID_TBTP2, 1'b0, 1'b0, 2'b00);
		tick();
		`STC_CHK("plan fresh", 1'b1, tbtp_fresh);
		tick();
		`STC_CHK("plan stale", 1'b0, tbtp_fresh);
		wrap_up();
	end
endmodule
